// >>> logic/dsa_sequencer.sv
// dual-slope converter sequencer with multiplexed bcd output and apb registers
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "dsa_consts.svh"
module dsa_sequencer
   import dsa_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        comp_trip_i,
   input  wire logic        input_neg_i,
   output dsa_switch_type   switches_o,
   output dsa_display_type  display_o,
   output logic             irq_o,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o
);

////////////////////////////////////////////////////////////////////////////////
// helpers

   function automatic logic [3:0] dig_of(input logic [11:0] v, input logic [1:0] pos);
      logic [11:0] t;
      t = v;
      if (pos == 2'd2) t = v / 12'd100;
      else if (pos == 2'd1) t = v / 12'd10;
      dig_of = 4'(t % 12'd10);
   endfunction

   // range tests are shared by the display code and the event flags
   function automatic logic is_over(input logic [11:0] v);
      is_over = (v > `DSA_FULL_SCALE);
   endfunction

   function automatic logic is_under(input logic [11:0] v);
      is_under = (v < `DSA_UNDER_LIMIT);
   endfunction

////////////////////////////////////////////////////////////////////////////////
// conversion phases

   dsa_phase_type phase_reg;
   dsa_phase_type phase_next;
   logic [11:0]   tmr_reg;
   logic [11:0]   ofs_reg;
   logic [11:0]   cnt_reg;
   logic [11:0]   result_reg;
   logic          neg_reg;
   logic          neg_seen_reg;
   logic          tmr_end;
   logic          ofs_end;
   logic          conv_done;
   logic          ofs_load;
   logic          cnt_clear;
   logic          cnt_run;
   logic [11:0]   tmr_next;
   logic [11:0]   cnt_next;
   logic          in_short;
   logic          in_offset;
   logic          in_ramp_up;
   logic          in_ref;

   // comparator decides the end of the offset count; the cap stops a dead comparator
   assign ofs_end = comp_trip_i || (tmr_reg == `DSA_OFFSET_MAX_CYCLES - 12'd1);

   always_comb
   begin
      phase_next = phase_reg;
      tmr_end    = 1'b0;
      case (phase_reg)
         PH_SHORT1, PH_SHORT2:
            tmr_end = (tmr_reg == `DSA_SHORT_CYCLES - 12'd1);
         PH_OFFSET:
            tmr_end = ofs_end;
         PH_RAMP_UP:
            tmr_end = (tmr_reg == `DSA_RAMP_UP_CYCLES - 12'd1);
         PH_ZERO_CORR:
            tmr_end = (tmr_reg + 12'd1 >= ofs_reg);
         PH_RAMP_DOWN:
            tmr_end = (tmr_reg == `DSA_SHORT_CYCLES - 12'd1);
         default:
            tmr_end = 1'b1;
      endcase
      if (tmr_end)
      begin
         case (phase_reg)
            PH_SHORT1:    phase_next = PH_OFFSET;
            PH_OFFSET:    phase_next = PH_SHORT2;
            PH_SHORT2:    phase_next = PH_RAMP_UP;
            PH_RAMP_UP:   phase_next = (ofs_reg == 12'd0) ? PH_RAMP_DOWN : PH_ZERO_CORR;
            PH_ZERO_CORR: phase_next = PH_RAMP_DOWN;
            default:      phase_next = PH_SHORT1;
         endcase
      end
   end

   assign conv_done = (phase_reg == PH_RAMP_DOWN) && tmr_end;
   assign ofs_load  = (phase_reg == PH_OFFSET) && tmr_end;
   assign tmr_next  = tmr_end ? 12'h000 : tmr_reg + 12'd1;

   // counts while the comparator has not yet tripped: ratio x 4000 up-ramp clocks, 1999 full scale
   // saturating, so a stuck comparator reads as overrange, not a wrapped value
   assign cnt_clear = (phase_reg == PH_RAMP_UP);
   assign cnt_run   = (phase_reg == PH_RAMP_DOWN) && !comp_trip_i && (cnt_reg != 12'hfff);
   assign cnt_next  = cnt_clear ? 12'h000
                    : (cnt_run ? cnt_reg + 12'd1 : cnt_reg);

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         phase_reg    <= PH_SHORT1;
         tmr_reg      <= 12'h000;
         ofs_reg      <= 12'h000;
         cnt_reg      <= 12'h000;
         result_reg   <= 12'h000;
         neg_reg      <= 1'b0;
         neg_seen_reg <= 1'b0;
      end
      else
      begin
         phase_reg <= phase_next;
         tmr_reg   <= tmr_next;
         cnt_reg   <= cnt_next;
         if (ofs_load)
            ofs_reg <= tmr_reg + 12'd1;
         // polarity follows the input to the end of the up ramp
         if (phase_reg == PH_RAMP_UP)
            neg_seen_reg <= input_neg_i;
         // result and its sign move together, so a read never mixes two conversions
         if (conv_done)
         begin
            result_reg <= cnt_reg;
            neg_reg    <= neg_seen_reg;
         end
      end
   end

   assign in_short   = (phase_reg == PH_SHORT1) || (phase_reg == PH_SHORT2);
   assign in_offset  = (phase_reg == PH_OFFSET);
   assign in_ramp_up = (phase_reg == PH_RAMP_UP);
   assign in_ref     = (phase_reg == PH_ZERO_CORR) || (phase_reg == PH_RAMP_DOWN);

   // switch levels decode straight from the phase, so they never lag a phase edge
   always_comb
   begin
      switches_o              = '0;
      switches_o.short_int    = in_short;
      switches_o.charge_ofs   = in_short;
      switches_o.sel_input    = in_ramp_up;
      // switch sense follows last conversion's polarity
      switches_o.invert_input = in_ramp_up && neg_reg;
      switches_o.sel_ref      = in_ref;
   end

////////////////////////////////////////////////////////////////////////////////
// range and digit multiplex

   logic       over;
   logic       under;
   logic [3:0] msd_code;
   logic       half;

   assign over     = is_over(result_reg);
   assign under    = is_under(result_reg);
   // an overrange reading clears half; bit3 still shows its leading one through over
   assign half     = (result_reg >= `DSA_HALF_LIMIT) && !over;
   // bit3 low for a one (and on overrange), bit2 polarity, bit0 out of range
   assign msd_code = {~(half | over), ~neg_reg, ~half, over | under};

   logic [6:0] mux_tmr_reg;
   logic [6:0] mux_tmr_next;
   logic [1:0] slot_reg;
   logic [1:0] slot_next;
   logic [3:0] bcd_reg;
   logic [3:0] bcd_next;
   logic       in_blank;
   logic       slot_end;

   // four slots of 20 clocks give one full scan per 80 clocks
   assign slot_end     = (mux_tmr_reg == `DSA_SLOT_CYCLES - 7'd1);
   assign mux_tmr_next = slot_end ? 7'd0 : mux_tmr_reg + 7'd1;
   assign slot_next    = slot_end ? slot_reg + 2'd1 : slot_reg;
   // the scan runs free of the conversion; a display may show the old result for a scan
   assign in_blank = (mux_tmr_reg < `DSA_BLANK_CYCLES);
   assign bcd_next = (slot_reg == 2'd0) ? msd_code
                                        : dig_of(result_reg, 2'(3 - slot_reg));

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mux_tmr_reg <= 7'd0;
         slot_reg    <= 2'd0;
         bcd_reg     <= 4'h0;
      end
      else
      begin
         mux_tmr_reg <= mux_tmr_next;
         slot_reg    <= slot_next;
         // data only moves during the gap, so a latched display never sees a glitch
         if (in_blank)
            bcd_reg <= bcd_next;
      end
   end

   assign display_o.bcd    = bcd_reg;
   assign display_o.strobe = in_blank ? 4'h0 : (4'h8 >> slot_reg);

////////////////////////////////////////////////////////////////////////////////
// events and apb slave

   logic [3:0]  ev_stat_reg;
   logic [3:0]  ev_stat_next;
   logic [3:0]  ev_en_reg;
   logic [3:0]  ev_set;
   logic [3:0]  ev_clr;
   logic [31:0] rdata_next;
   logic        wr_acc;
   logic        rd_setup;
   logic        hit_status;
   logic        hit_result;
   logic        hit_en;
   logic        hit_clr;
   logic        hit;

   assign ev_set[`DSA_EV_DONE]        = conv_done;
   assign ev_set[`DSA_EV_OVER]        = conv_done && is_over(cnt_reg);
   assign ev_set[`DSA_EV_UNDER]       = conv_done && is_under(cnt_reg);
   // a dead comparator shows up here and as an overrange count; the phase still ends at the cap
   assign ev_set[`DSA_EV_OFS_TIMEOUT] = in_offset && ofs_end && !comp_trip_i;

   assign hit_status = (paddr_i == `DSA_ADDR_STATUS);
   assign hit_result = (paddr_i == `DSA_ADDR_RESULT);
   assign hit_en     = (paddr_i == `DSA_ADDR_IRQ_EN);
   assign hit_clr    = (paddr_i == `DSA_ADDR_IRQ_CLR);
   assign hit        = hit_status || hit_result || hit_en || hit_clr;

   // zero wait states: every access completes in its first access cycle
   assign wr_acc    = psel_i && penable_i && pwrite_i && hit;
   assign rd_setup  = psel_i && !penable_i && !pwrite_i;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !hit;
   assign irq_o     = |(ev_stat_reg & ev_en_reg);

   // a new event beats a clear in the same cycle
   assign ev_clr       = (wr_acc && hit_clr) ? pwdata_i[3:0] : 4'h0;
   assign ev_stat_next = (ev_stat_reg & ~ev_clr) | ev_set;

   // read data is captured in the setup cycle and stands through the access cycle
   assign rdata_next = hit_status ? {24'h00_0000, phase_reg, neg_reg, ev_stat_reg}
                     : hit_result ? {16'h0000, over, under, 1'b0, neg_reg, result_reg}
                     : hit_en     ? {28'h000_0000, ev_en_reg}
                     : 32'h0000_0000;

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ev_stat_reg <= 4'h0;
         ev_en_reg   <= 4'h0;
         prdata_o    <= 32'h0000_0000;
      end
      else
      begin
         ev_stat_reg <= ev_stat_next;
         if (wr_acc && hit_en)
            ev_en_reg <= pwdata_i[3:0];
         if (rd_setup)
            prdata_o <= rdata_next;
      end
   end

endmodule

// >>> logic/dsa_consts.svh
// timing counts, limits and codes for the dual-slope converter sequencer
`ifndef DSA_CONSTS_SVH
`define DSA_CONSTS_SVH
`define DSA_SHORT_CYCLES      12'd4000
`define DSA_OFFSET_MAX_CYCLES 12'd800
`define DSA_RAMP_UP_CYCLES    12'd4000
`define DSA_FULL_SCALE        12'd1999
`define DSA_HALF_LIMIT        12'd1000
`define DSA_UNDER_LIMIT       12'd180
`define DSA_MUX_DIV           7'd80
`define DSA_SLOT_CYCLES       7'd20
`define DSA_BLANK_CYCLES      7'd2
`define DSA_ADDR_STATUS       12'h000
`define DSA_ADDR_RESULT       12'h004
`define DSA_ADDR_IRQ_EN       12'h008
`define DSA_ADDR_IRQ_CLR      12'h00c
`define DSA_EV_DONE           0
`define DSA_EV_OVER           1
`define DSA_EV_UNDER          2
`define DSA_EV_OFS_TIMEOUT    3
`define DSA_EV_BITS           4
`endif

// >>> logic/dsa_pkg.sv
// types for the dual-slope converter sequencer
package dsa_pkg;
   typedef enum logic [2:0] {
      PH_SHORT1, PH_OFFSET, PH_SHORT2, PH_RAMP_UP, PH_ZERO_CORR, PH_RAMP_DOWN
   } dsa_phase_type;
   typedef struct packed {
      logic short_int;
      logic charge_ofs;
      logic sel_input;
      logic invert_input;
      logic sel_ref;
   } dsa_switch_type;
   typedef struct packed {
      logic [3:0] strobe;
      logic [3:0] bcd;
   } dsa_display_type;
endpackage

// >>> test/dsa_props.sv
// assertions on the sequencer switch and display outputs
`timescale 1ns/1ps
module dsa_props
   import dsa_pkg::*;
(
   input wire logic            mclk_i,
   input wire logic            rst_i,
   input wire dsa_switch_type  switches_o,
   input wire dsa_display_type display_o
);
   logic [12:0] n_sh;
   logic [12:0] n_ref;
   logic [12:0] n_p2;
   logic [12:0] ofs;
   wire         ph2 = !(switches_o.short_int | switches_o.sel_input | switches_o.sel_ref);
   wire  [3:0]  s   = display_o.strobe;
   ////////////////////////////////////////////////////////////////////////////
   // run lengths; offset phase taken as all three path switches open
   always_ff @(posedge mclk_i or posedge rst_i)
      if (rst_i)
      begin
         n_sh  <= 13'h0;
         n_ref <= 13'h0;
         n_p2  <= 13'h0;
         ofs   <= 13'h0;
      end
      else
      begin
         n_sh  <= switches_o.short_int ? n_sh + 13'h1 : 13'h0;
         n_ref <= switches_o.sel_ref ? n_ref + 13'h1 : 13'h0;
         n_p2  <= ph2 ? n_p2 + 13'h1 : 13'h0;
         if (!ph2 && n_p2 != 13'h0)
            ofs <= n_p2;
      end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   property p_onehot; $onehot0(s); endproperty
   a_onehot: assert property (p_onehot) else $error("two strobes at once");
   property p_gap; $rose(|s) |-> $past(s, 2) == 4'h0; endproperty
   a_gap: assert property (p_gap) else $error("strobe gap too short");
   property p_hold; $rose(|s) |=> $stable(s)[*8]; endproperty
   a_hold: assert property (p_hold) else $error("strobe too short");
   property p_bcd; |s && $past(|s) |-> $stable(display_o.bcd); endproperty
   a_bcd: assert property (p_bcd) else $error("bcd moved under strobe");
   property p_rate; $rose(s[3]) |-> ##80 $rose(s[3]); endproperty
   a_rate: assert property (p_rate) else $error("scan not 80 clocks");
   property p_order; $fell(s[3]) |-> ##2 s[2]; endproperty
   a_order: assert property (p_order) else $error("digit order wrong");
   property p_short; $fell(switches_o.short_int) |-> n_sh == 13'hfa0; endproperty
   a_short: assert property (p_short) else $error("short phase length");
   property p_ofs; ph2 |-> n_p2 < 13'h320; endproperty
   a_ofs: assert property (p_ofs) else $error("offset phase too long");
   property p_ref; $fell(switches_o.sel_ref) |-> n_ref == ofs + 13'hfa0; endproperty
   a_ref: assert property (p_ref) else $error("reference ramp length");
   property p_seq; $rose(switches_o.sel_input) |-> $past(switches_o.short_int); endproperty
   a_seq: assert property (p_seq) else $error("ramp up out of order");
   property p_inv; switches_o.invert_input |-> switches_o.sel_input; endproperty
   a_inv: assert property (p_inv) else $error("inverted input outside ramp up");
endmodule

// >>> test/dsa_disp_model.sv
// display demultiplexer keeping the last nibble seen under each strobe
`timescale 1ns/1ps
module dsa_disp_model
   import dsa_pkg::*;
(
   input  wire logic            mclk_i,
   input  wire dsa_display_type display_i,
   output logic [15:0]          digits_o
);
   // latch only under a strobe, so gap data never reaches a digit
   always_ff @(posedge mclk_i)
      for (int i = 0; i < 4; i++)
         if (display_i.strobe[i])
            digits_o[i*4 +: 4] <= display_i.bcd;
endmodule

// >>> test/tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb;
   import dsa_pkg::*;
   logic            mclk_i = 1'b0, rst_i = 1'b1, comp_trip_i = 1'b0, input_neg_i = 1'b0;
   logic            psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pready_o, pslverr_o;
   logic [11:0]     paddr_i = 12'h0;
   logic [31:0]     pwdata_i = 32'h0, prdata_o, rd, e;
   logic            irq_o, err;
   dsa_switch_type  switches_o;
   dsa_display_type display_o;
   logic [15:0]     digits;
   logic [12:0]     p2 = 13'h0, r = 13'h0, ofs = 13'h0, cnt = 13'h3e8;
   int              mismatches = 0, compares = 0;
   always #20 mclk_i = ~mclk_i;
   dsa_sequencer i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .comp_trip_i(comp_trip_i),
      .input_neg_i(input_neg_i), .switches_o(switches_o), .display_o(display_o),
      .irq_o(irq_o), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o));
   dsa_disp_model i_disp (.mclk_i(mclk_i), .display_i(display_o), .digits_o(digits));
   ////////////////////////////////////////////////////////////////////////////
   // comparator stub: trips 9 clocks into offset phase, cnt clocks into result phase
   wire ph2 = !(switches_o.short_int | switches_o.sel_input | switches_o.sel_ref);
   always @(posedge mclk_i)
   begin
      p2 <= ph2 ? p2 + 13'h1 : 13'h0;
      if (!ph2 && p2 != 13'h0)
         ofs <= p2;
      r <= switches_o.sel_ref ? r + 13'h1 : 13'h0;
      comp_trip_i <= (ph2 && p2 >= 13'h8) || (switches_o.sel_ref && r + 13'h1 >= ofs + cnt);
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do
         @(posedge mclk_i);
      while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // starts on a falling edge so a clear landing this step is not missed
   task automatic wait_irq;
      @(negedge mclk_i);
      for (int i = 0; i < 20000 && irq_o !== 1'b1; i++)
         @(posedge mclk_i);
      chk(32'h1, {31'h0, irq_o});
   endtask
   task automatic t_regs;
      apb(1'b1, 12'h008, 32'h1);
      apb(1'b0, 12'h008, 32'h0);
      chk(32'h1, rd & 32'hf);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, 1'b1}, {31'h0, err});
      chk(32'h0, rd);
   endtask
   task automatic t_conv(input logic [12:0] c, input logic n);
      logic h;
      logic o;
      logic u;
      int   v;
      h = c >= 13'h3e8 && c <= 13'h7cf;
      o = c > 13'h7cf;
      u = c < 13'h0b4;
      v = int'(c) % 1000;
      cnt <= c;
      input_neg_i <= n;
      apb(1'b1, 12'h00c, 32'hf);
      wait_irq();
      apb(1'b0, 12'h000, 32'h0);
      chk({28'h0, 1'b0, u, o, 1'b1}, rd & 32'hf);
      apb(1'b0, 12'h004, 32'h0);
      chk({16'h0, o, u, 1'b0, n, c[11:0]}, rd & 32'hdfff);
      repeat (200) @(posedge mclk_i);
      e = {16'h0, ~(h | o), ~n, ~h, o | u, 12'h0};
      if (!o)
         e[11:0] = {4'(v / 100), 4'(v / 10 % 10), 4'(v % 10)};
      chk(e, {16'h0, digits[15:12], o ? 12'h0 : digits[11:0]});
   endtask
   task automatic t_irq;
      apb(1'b1, 12'h008, 32'h0);
      @(negedge mclk_i);
      chk(32'h0, {31'h0, irq_o});
      apb(1'b1, 12'h008, 32'h1);
      @(negedge mclk_i);
      chk(32'h1, {31'h0, irq_o});
      apb(1'b1, 12'h00c, 32'hf);
      @(negedge mclk_i);
      chk(32'h0, {31'h0, irq_o});
   endtask
   task automatic print_verdict;
      if (mismatches == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (100000) @(posedge mclk_i);
      mismatches++;
      print_verdict();
   end
   initial
   begin
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      t_regs();
      wait_irq();
      t_conv(13'h096, 1'b1);
      t_conv(13'h0b4, 1'b0);
      t_conv(13'h7cf, 1'b1);
      t_conv(13'h9c4, 1'b0);
      t_irq();
      print_verdict();
   end
endmodule
bind dsa_sequencer dsa_props i_props (.mclk_i(mclk_i), .rst_i(rst_i),
   .switches_o(switches_o), .display_o(display_o));
